//--- verilog/eeprom_defs.svh
// Purpose: shared constants of the two-wire eeprom slave front end
// Assumes: included by bare name; definitions only
// Notes: counts and bus codes used by the logic are named here; state codes are in eeprom_pkg
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// fixed upper five bits of the device address word: 1010 then 0
`define DEV_TYPE_CODE 5'h14
// bit counter values: first and last data bit and the acknowledge clock
`define BIT_FIRST 4'h0
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
// array geometry
`define WORD_ADDR_W 15
`define PAGE_OFF_W 6
`define PAGE_BYTES 64
// self-timed program time in its own unit and the core clock rate
`define SELF_TIMED_PROGRAM_TIME_MS 5
`define CLK_FREQ_KHZ 100000
// synchroniser reset value for {scl, sda, wp, cs_high, cs_low}
`define PIN_IDLE 5'h18

`endif

//--- verilog/eeprom_pkg.sv
// Purpose: types shared by the eeprom slave files
// Assumes: nothing imported; users write eeprom_pkg::name
// Notes: pin bundle travels through the synchroniser as one word
package eeprom_pkg;

    // protocol states of the slave core
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101,
        ST_PROG = 3'b110
    } slave_state_t;

    // pins sampled into the core clock domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic write_protect;
        logic chip_select_bit_high;
        logic chip_select_bit_low;
    } pin_bundle_t;

endpackage : eeprom_pkg

//--- verilog/level_sync2.sv
// Purpose: two flip-flop synchroniser for slow level inputs
// Assumes: i_rst_b synchronous, active low
// Notes: first stage is read by the second stage only
module level_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // next values: plain shift, reset to the idle pin levels
    always_comb
    begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
        if (!i_rst_b)
        begin
            meta_nxt = RESET_VAL;
            sync_nxt = RESET_VAL;
        end
    end

    // registers only
    always_ff @(posedge i_clock)
    begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign o_sync = sync_r;

endmodule : level_sync2

//--- verilog/two_wire_eeprom.sv
// Purpose: write side of a two-wire serial eeprom slave with page buffer
// Assumes: i_clock 100 MHz far above the serial clock; bus pull-up outside
// Notes: read transfers are acknowledged but carry no data out
`include "eeprom_defs.svh"

// Function
// - data changes only while clock is low
// - sda falling with scl high starts
// - sda rising with scl high stops
// - idle standby at power-up and after stop
// - bytes msb first, ack on ninth clock
// - device word upper five bits must match
// - two chip-select bits compared with pins
// - unconnected chip-select pins read low
// - eighth address bit selects read or write
// - match acknowledges; mismatch no ack, ignored until stop
// - write-protect high blocks all array writes
// - two address bytes then data, each acknowledged
// - programming ignores bus, gives no ack
// - programming finishes within five milliseconds
// - page writes up to 64 bytes
// - only low six address bits increment, wrap
// - no address ack while programming, then ack
// - 64-byte pages, 14 or 15 address bits
module two_wire_eeprom #(
    parameter int WORD_ADDR_W = `WORD_ADDR_W,
    parameter int PROG_CYCLES =
        `SELF_TIMED_PROGRAM_TIME_MS * `CLK_FREQ_KHZ
) (
    // core clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // serial clock, clocks the link-side shifter
    input wire logic i_scl,
    // serial data pin, open drain
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // hardwired straps
    input wire logic i_chip_select_bit_high,
    input wire logic i_chip_select_bit_low,
    input wire logic i_write_protect,
    // status
    output logic o_standby,
    output logic o_programming,
    // array inspection port
    input wire logic [WORD_ADDR_W-1:0] i_peek_addr,
    output logic [7:0] o_peek_data
);

    localparam int OFF_W = `PAGE_OFF_W;
    localparam int PAGE_W = WORD_ADDR_W - OFF_W;
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);
    localparam logic [PCW-1:0] PAGE_LAST = PCW'(`PAGE_BYTES - 1);

    eeprom_pkg::pin_bundle_t pins_raw, pins_s;
    eeprom_pkg::slave_state_t state_r, state_nxt;
    logic [7:0] link_shift_r, link_shift_nxt;
    logic scl_d_r, sda_d_r;
    logic scl_rise, scl_fall;
    logic start_evt, stop_evt;
    logic byte_done;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic ack_pend_r, ack_pend_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [PAGE_W-1:0] page_r, page_nxt;
    logic [OFF_W-1:0] off_r, off_nxt;
    logic [`PAGE_BYTES-1:0] pmask_r, pmask_nxt;
    logic [PCW-1:0] prog_cnt_r, prog_cnt_nxt;
    logic [7:0] peek_r;
    logic pbuf_we, mem_we;
    logic [15:0] word_addr;
    logic [7:0] pbuf [`PAGE_BYTES];
    logic [7:0] mem [2**WORD_ADDR_W];

    // device word: type code, chip selects, direction in bit 0
    function automatic logic dev_match(input logic [7:0] word,
        input logic cs_hi, input logic cs_lo);
        return (word[7:3] == `DEV_TYPE_CODE) &&
            (word[2:1] == {cs_hi, cs_lo});
    endfunction : dev_match

    // link side: sda is sampled at the serial clock's own rising edge
    // msb first shift
    always_comb
        link_shift_nxt = {link_shift_r[6:0], i_sda};

    // no reset here: the serial clock may stand still at any time
    always_ff @(posedge i_scl)
        link_shift_r <= link_shift_nxt;

    // pads pull the chip selects low when left open
    assign pins_raw = '{scl: i_scl, sda: i_sda,
        write_protect: i_write_protect,
        chip_select_bit_high: i_chip_select_bit_high,
        chip_select_bit_low: i_chip_select_bit_low};

    // all pins cross into the core clock for edge and strap decisions; byte values come from the scl-clocked shifter
    level_sync2 #(
        .WIDTH(5),
        .RESET_VAL(`PIN_IDLE)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    // edge detection on the synchronised copies
    // sda edges with scl high are conditions, not data
    assign scl_rise = pins_s.scl && !scl_d_r;
    assign scl_fall = !pins_s.scl && scl_d_r;
    assign start_evt = pins_s.scl && scl_d_r && sda_d_r && !pins_s.sda;
    assign stop_evt = pins_s.scl && scl_d_r && !sda_d_r && pins_s.sda;
    // link byte is stable for a whole scl period after the 8th rise
    assign byte_done = scl_rise && (bit_cnt_r == `BIT_LAST) &&
        (state_r inside {eeprom_pkg::ST_DEV, eeprom_pkg::ST_ADDR_HI,
        eeprom_pkg::ST_ADDR_LO, eeprom_pkg::ST_DATA});
    // unused high bits drop out of the page index
    assign word_addr = {hi_r, link_shift_r};

    // protocol next-state logic
    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        ack_pend_nxt = ack_pend_r;
        oe_nxt = oe_r;
        hi_nxt = hi_r;
        page_nxt = page_r;
        off_nxt = off_r;
        pmask_nxt = pmask_r;
        prog_cnt_nxt = prog_cnt_r;
        pbuf_we = 1'b0;
        mem_we = 1'b0;
        // bit counter runs 0..8, the ninth clock being the ack slot
        if (scl_rise)
            bit_cnt_nxt = (bit_cnt_r == `BIT_ACK) ? `BIT_FIRST
                : bit_cnt_r + 4'h1;
        // drive low from the fall after bit 8 to the fall after 9
        if (scl_fall && ack_pend_r && bit_cnt_r == `BIT_ACK)
        begin
            oe_nxt = 1'b1;
            ack_pend_nxt = 1'b0;
        end
        else if (scl_fall && oe_r && bit_cnt_r == `BIT_FIRST)
            oe_nxt = 1'b0;
        if (byte_done)
        begin
            case (state_r)
                eeprom_pkg::ST_DEV:
                begin
                    // ack on match, else drop to ignore
                    if (dev_match(link_shift_r, pins_s.chip_select_bit_high,
                        pins_s.chip_select_bit_low))
                    begin
                        ack_pend_nxt = 1'b1;
                        state_nxt = link_shift_r[0] ? eeprom_pkg::ST_IGNORE
                            : eeprom_pkg::ST_ADDR_HI;
                    end
                    else
                        state_nxt = eeprom_pkg::ST_IGNORE;
                end
                eeprom_pkg::ST_ADDR_HI:
                begin
                    hi_nxt = link_shift_r;
                    ack_pend_nxt = 1'b1;
                    state_nxt = eeprom_pkg::ST_ADDR_LO;
                end
                eeprom_pkg::ST_ADDR_LO:
                begin
                    page_nxt = word_addr[WORD_ADDR_W-1:OFF_W];
                    off_nxt = word_addr[OFF_W-1:0];
                    ack_pend_nxt = 1'b1;
                    state_nxt = eeprom_pkg::ST_DATA;
                end
                eeprom_pkg::ST_DATA:
                begin
                    ack_pend_nxt = 1'b1;
                    pbuf_we = 1'b1;
                    // protected bytes never reach the mask
                    if (!pins_s.write_protect)
                        pmask_nxt[off_r] = 1'b1;
                    off_nxt = off_r + OFF_W'(1);
                end
                default:
                    state_nxt = state_r;
            endcase
        end
        if (state_r == eeprom_pkg::ST_PROG)
        begin
            ack_pend_nxt = 1'b0;
            oe_nxt = 1'b0;
            prog_cnt_nxt = prog_cnt_r + PCW'(1);
            mem_we = (prog_cnt_r <= PAGE_LAST) &&
                pmask_r[prog_cnt_r[OFF_W-1:0]];
            if (prog_cnt_r == PROG_LAST)
            begin
                state_nxt = eeprom_pkg::ST_IDLE;
                pmask_nxt = '0;
            end
        end
        else if (start_evt)
        begin
            // every command begins here; restart drops pending data
            state_nxt = eeprom_pkg::ST_DEV;
            bit_cnt_nxt = `BIT_FIRST;
            ack_pend_nxt = 1'b0;
            oe_nxt = 1'b0;
            pmask_nxt = '0;
        end
        else if (stop_evt)
        begin
            ack_pend_nxt = 1'b0;
            oe_nxt = 1'b0;
            // stop after accepted data starts programming
            if (state_r == eeprom_pkg::ST_DATA && pmask_r != '0)
            begin
                state_nxt = eeprom_pkg::ST_PROG;
                prog_cnt_nxt = '0;
            end
            else
            begin
                state_nxt = eeprom_pkg::ST_IDLE;
                pmask_nxt = '0;
            end
        end
        if (!i_rst_b)
        begin
            state_nxt = eeprom_pkg::ST_IDLE;
            bit_cnt_nxt = `BIT_FIRST;
            ack_pend_nxt = 1'b0;
            oe_nxt = 1'b0;
            hi_nxt = 8'h00;
            page_nxt = '0;
            off_nxt = '0;
            pmask_nxt = '0;
            prog_cnt_nxt = '0;
            pbuf_we = 1'b0;
            mem_we = 1'b0;
        end
    end

    // protocol registers
    always_ff @(posedge i_clock)
    begin
        state_r <= state_nxt;
        bit_cnt_r <= bit_cnt_nxt;
        ack_pend_r <= ack_pend_nxt;
        oe_r <= oe_nxt;
        hi_r <= hi_nxt;
        page_r <= page_nxt;
        off_r <= off_nxt;
        pmask_r <= pmask_nxt;
        prog_cnt_r <= prog_cnt_nxt;
        scl_d_r <= i_rst_b ? pins_s.scl : 1'b1;
        sda_d_r <= i_rst_b ? pins_s.sda : 1'b1;
    end

    // storage: page buffer fill and array commit, no reset on data
    // one 64-byte buffer, committed a byte a cycle
    always_ff @(posedge i_clock)
    begin
        if (pbuf_we)
            pbuf[off_r] <= link_shift_r;
        if (mem_we)
            mem[{page_r, prog_cnt_r[OFF_W-1:0]}] <=
                pbuf[prog_cnt_r[OFF_W-1:0]];
        peek_r <= i_rst_b ? mem[i_peek_addr] : 8'h00;
    end

    // outputs: pin only ever pulled low
    assign o_sda = 1'b0;
    assign o_sda_oe = oe_r;
    assign o_standby = (state_r == eeprom_pkg::ST_IDLE);
    assign o_programming = (state_r == eeprom_pkg::ST_PROG);
    assign o_peek_data = peek_r;

    // checks on the core clock domain
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_start_seen;
        start_evt && state_r != eeprom_pkg::ST_PROG;
    endsequence
    sequence s_ack_slot;
        scl_fall && ack_pend_r && bit_cnt_r == `BIT_ACK;
    endsequence
    property p_start_enters_dev;
        s_start_seen |=> state_r == eeprom_pkg::ST_DEV &&
            bit_cnt_r == `BIT_FIRST;
    endproperty
    a_start_enters_dev: assert property (p_start_enters_dev)
        else $error("start did not open a device word");
    property p_stop_idles;
        stop_evt && state_r inside {eeprom_pkg::ST_DEV,
            eeprom_pkg::ST_IGNORE} |=> o_standby;
    endproperty
    a_stop_idles: assert property (p_stop_idles)
        else $error("stop did not return to standby");
    property p_ack_driven;
        s_ack_slot |=> o_sda_oe [*2];
    endproperty
    a_ack_driven: assert property (p_ack_driven)
        else $error("ack not driven on the ninth clock");
    property p_oe_after_fall;
        $rose(o_sda_oe) |-> $past(scl_fall) && !pins_s.scl;
    endproperty
    a_oe_after_fall: assert property (p_oe_after_fall)
        else $error("sda driven outside clock low time");
    property p_mismatch_no_ack;
        byte_done && state_r == eeprom_pkg::ST_DEV &&
            link_shift_r[7:3] != `DEV_TYPE_CODE
            |=> state_r == eeprom_pkg::ST_IGNORE && !ack_pend_r;
    endproperty
    a_mismatch_no_ack: assert property (p_mismatch_no_ack)
        else $error("mismatched device word acknowledged");
    property p_prog_silent;
        state_r == eeprom_pkg::ST_PROG |-> !o_sda_oe && !ack_pend_r;
    endproperty
    a_prog_silent: assert property (p_prog_silent)
        else $error("acknowledge during programming");
    property p_prog_ends;
        state_r == eeprom_pkg::ST_PROG && prog_cnt_r == PROG_LAST
            |=> o_standby && pmask_r == '0;
    endproperty
    a_prog_ends: assert property (p_prog_ends)
        else $error("programming overran its time");
    property p_page_wrap;
        byte_done && state_r == eeprom_pkg::ST_DATA && off_r == '1
            |=> off_r == '0 && $stable(page_r);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page offset did not wrap");
    property p_protect_blocks;
        byte_done && state_r == eeprom_pkg::ST_DATA && pins_s.write_protect
            |=> $stable(pmask_r) && ack_pend_r;
    endproperty
    a_protect_blocks: assert property (p_protect_blocks)
        else $error("protected byte marked for write");
    property p_addr_then_data;
        byte_done && state_r == eeprom_pkg::ST_ADDR_LO
            |=> state_r == eeprom_pkg::ST_DATA && ack_pend_r;
    endproperty
    a_addr_then_data: assert property (p_addr_then_data)
        else $error("second address byte not taken");

endmodule : two_wire_eeprom

//--- tb/bus_master_model.sv
// Purpose: bus master model driving serial clock and data
// Assumes: bench resolves the open-drain data wire with a pull-up
// Notes: serial clock stands still between frames; 12 ns step base
module bus_master_model (
    // resolved data wire
    input wire logic i_sda,
    // driven lines
    output logic o_scl,
    output logic o_sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam time STEP = 12ns;

    // idle bus: both lines released high
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // data moves mid low phase, sampled at high
    task automatic put_bit(input logic b, output logic seen);
        #(4*STEP) o_sda_oe = ~b;
        #(4*STEP) o_scl = 1'b1;
        #(3*STEP) seen = i_sda;
        #(3*STEP) o_scl = 1'b0;
    endtask : put_bit

    // falling data with clock high opens a frame
    task automatic start;
        o_sda_oe = 1'b0;
        #(4*STEP) o_scl = 1'b1;
        #(4*STEP) o_sda_oe = 1'b1;
        #(4*STEP) o_scl = 1'b0;
    endtask : start

    // rising data with clock high closes a frame
    task automatic stop;
        #(4*STEP) o_sda_oe = 1'b1;
        #(4*STEP) o_scl = 1'b1;
        #(4*STEP) o_sda_oe = 1'b0;
    endtask : stop

    // msb first, ack read on the ninth clock
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // recovery: nine clocks with data released, then start
    task automatic recover;
        logic s;
        o_scl = 1'b0;
        repeat (9) put_bit(1'b1, s);
        start();
    endtask : recover
endmodule : bus_master_model

//--- tb/two_wire_eeprom_test.sv
// Purpose: self-checking bench of the eeprom slave write path
// Assumes: program time shortened to PROG core cycles
// Notes: straps and write protect changed between frames, at least four core cycles ahead of the next one
module two_wire_eeprom_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PROG = 400;
    logic clock, rst_b, scl, m_oe, d_oe, wp, cs_hi, cs_lo;
    logic standby, programming, sda_val;
    logic [14:0] peek_addr;
    logic [7:0] peek_data;
    logic [7:0] dev_tab [3];
    logic ack;
    wire logic sda_wire;
    int fails = 0;
    int checks = 0;

    // open drain with pull-up: low when anyone pulls
    assign sda_wire = ~(m_oe | (d_oe & ~sda_val));

    two_wire_eeprom #(.WORD_ADDR_W(15), .PROG_CYCLES(PROG)) uut (
        .i_clock(clock), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_wire),
        .o_sda(sda_val), .o_sda_oe(d_oe), .i_chip_select_bit_high(cs_hi),
        .i_chip_select_bit_low(cs_lo), .i_write_protect(wp),
        .o_standby(standby), .o_programming(programming),
        .i_peek_addr(peek_addr), .o_peek_data(peek_data));

    bus_master_model m (.i_sda(sda_wire), .o_scl(scl), .o_sda_oe(m_oe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // cycles, then settle just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // one write frame of n bytes, taken from d top byte first
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
        input int n);
        m.start();
        m.send_byte(8'ha4, ack);
        check(16'(ack), 16'h1);
        m.send_byte(a[15:8], ack);
        check(16'(ack), 16'h1);
        m.send_byte(a[7:0], ack);
        check(16'(ack), 16'h1);
        for (int i = 0; i < n; i++)
        begin
            m.send_byte(d[31-8*i -: 8], ack);
            check(16'(ack), 16'h1);
        end
        m.stop();
    endtask : wr

    // program cycle: optional busy poll, bounded length
    task automatic settle(input logic poll);
        time t0;
        int n;
        t0 = $time;
        cyc(8);
        check(16'(programming), 16'h1);
        if (poll)
        begin
            m.start();
            m.send_byte(8'ha4, ack);
            check(16'(ack), 16'h0);
            m.stop();
        end
        n = 0;
        while (programming === 1'b1 && n < 2000)
        begin
            n++;
            cyc(1);
        end
        n = int'(($time - t0) / 10);
        check(16'(n >= PROG && n <= PROG + 12), 16'h1);
        check(16'(standby), 16'h1);
    endtask : settle

    task automatic peek(input logic [14:0] a, input logic [7:0] e);
        peek_addr = a;
        cyc(2);
        check(16'(peek_data), 16'(e));
    endtask : peek

    // core clock, 100 MHz
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard, well beyond the expected run
    initial
    begin
        #500us;
        fails++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        wp = 1'b0;
        cs_hi = 1'b1;
        cs_lo = 1'b0;
        peek_addr = 15'h0000;
        cyc(5);
        check({standby, programming, d_oe, sda_val, 4'h0, peek_data},
            16'h8000);
        cyc(1);
        rst_b = 1'b1;
        cyc(4);
        m.recover();
        // byte write with a busy poll, then a read-back through the peek port
        wr(16'h1234, 32'h5a00_0000, 1);
        settle(1'b1);
        peek(15'h1234, 8'h5a);
        // page wrap; top address bit is ignored
        wr(16'h813e, 32'h1011_1213, 4);
        settle(1'b1);
        peek(15'h013e, 8'h10);
        peek(15'h013f, 8'h11);
        peek(15'h0100, 8'h12);
        peek(15'h0101, 8'h13);
        // protected write is acknowledged but changes nothing
        wr(16'h0200, 32'h7700_0000, 1);
        settle(1'b0);
        wp = 1'b1;
        cyc(4);
        wr(16'h0200, 32'hc300_0000, 1);
        cyc(8);
        check(16'(programming), 16'h0);
        peek(15'h0200, 8'h77);
        wp = 1'b0;
        // straps: match, wrong select, wrong fixed bit
        for (int k = 0; k < 4; k++)
        begin
            {cs_hi, cs_lo} = 2'(k);
            cyc(4);
            dev_tab[0] = 8'ha0 | 8'(k << 1);
            dev_tab[1] = 8'ha0 | 8'((k ^ 1) << 1);
            dev_tab[2] = 8'ha8 | 8'(k << 1);
            for (int j = 0; j < 3; j++)
            begin
                m.start();
                m.send_byte(dev_tab[j], ack);
                check(16'(ack), 16'(j == 0));
                m.send_byte(8'h00, ack);
                check(16'(ack), 16'(j == 0));
                m.stop();
            end
        end
        // read direction: address acked, nothing after it
        {cs_hi, cs_lo} = 2'b10;
        cyc(4);
        m.start();
        m.send_byte(8'ha5, ack);
        check(16'(ack), 16'h1);
        m.send_byte(8'hff, ack);
        check(16'(ack), 16'h0);
        m.stop();
        cyc(8);
        check({programming, standby}, 16'h1);
        results();
    end
endmodule : two_wire_eeprom_test
